// File: pkg/ebc_pkg.sv
// Functional notes
// - four page selects decode address bits 23:22 during external strobe only
// - page selects share exactly the strobe's assertion and release timing
// - one shared bus control register governs every external access
// - combined ready is sampled on each rising bus clock edge
// - control bits 4:3 pick ready source: ext, counter, and, or (default)
// - and mode: ready low gives zero waits, else counter sets length
// - or mode: never before counter and bank logic; extended while ready high
// - bank compare adds one null cycle before a read to another bank
// - writes are posted into a single-entry latch; core continues
// - reset ends any pending access at once and floats pins immediately
// - reset with float input asserted floats all pins at once
// - float input low disables all outputs asynchronously
// - data keeper holds last value whenever undriven, off only under float
// - reset clears the wait counter and ends bus activity asynchronously
package ebc_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_BANK = 8'h08;
	localparam int CTRL_WAIT_LSB = 5;
	localparam int CTRL_WAIT_W = 3;
	localparam int CTRL_SRC_LSB = 3;
	localparam int CTRL_BNK_LSB = 0;
	localparam int CTRL_BNK_W = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_00F8;
	localparam int SAFE_EXIT_CYCLES = 10;
	localparam int CLK_PERIOD_NS = 10;
	typedef enum logic [1:0]
	{
		EBC_SRC_EXT = 2'b00,
		EBC_SRC_CNT = 2'b01,
		EBC_SRC_AND = 2'b10,
		EBC_SRC_OR = 2'b11
	} ebc_src_t;
	typedef enum logic [1:0]
	{
		EBC_IDLE = 2'b00,
		EBC_NULL = 2'b01,
		EBC_ACCESS = 2'b10,
		EBC_HALT = 2'b11
	} ebc_state_t;
	typedef struct packed
	{
		logic write;
		logic [23:0] addr;
		logic [31:0] data;
	} ebc_req_t;
endpackage : ebc_pkg

// File: rtl/ebc_bus_ctrl.sv
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_ctrl
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic core_req,
	input wire ebc_pkg::ebc_req_t core_cmd,
	output logic core_ack,
	output logic [31:0] core_rdata,
	output logic core_rvalid,
	input wire logic output_float_n,
	input wire logic ext_ready_n,
	output logic [23:0] addr_out,
	output logic addr_oe_n,
	output logic [31:0] data_out,
	output logic data_oe_n,
	input wire logic [31:0] data_in,
	output logic [31:0] keeper_value,
	output logic keeper_en,
	output logic external_access_strobe,
	output logic rw_out,
	output logic ctrl_oe_n,
	output logic page_select_q0,
	output logic page_select_q1,
	output logic page_select_q2,
	output logic page_select_q3
);
	ebc_pkg::ebc_state_t state;
	logic [31:0] ctrl;
	logic [2:0] wait_cnt;
	logic float_done;
	logic have_bank;
	logic [2:0] last_bank_bits;
	logic posted_valid;
	ebc_pkg::ebc_req_t posted;
	ebc_pkg::ebc_req_t cur;
	logic cnt_ready;
	logic ext_ok;
	logic combined_ready;
	logic bank_hit;
	logic apb_wr;
	logic start;
	logic [1:0] src;
	logic [2:0] bank_mask;

	// bank field of an address under the configured mask
	function automatic logic [2:0] bank_of(input logic [23:0] a, input logic [2:0] m);
		bank_of = a[23:21] & m;
	endfunction : bank_of

	// every access reads the one shared control register
	assign src = ctrl[ebc_pkg::CTRL_SRC_LSB +: 2];
	assign bank_mask = ctrl[ebc_pkg::CTRL_BNK_LSB +: ebc_pkg::CTRL_BNK_W];
	assign apb_wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr != ebc_pkg::ADDR_CTRL)
		&& (paddr != ebc_pkg::ADDR_STATUS) && (paddr != ebc_pkg::ADDR_BANK);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= ebc_pkg::CTRL_RESET;
		else if (apb_wr && paddr == ebc_pkg::ADDR_CTRL)
			ctrl <= {24'h000000, pwdata[7:0]};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				ebc_pkg::ADDR_CTRL: prdata <= ctrl;
				ebc_pkg::ADDR_STATUS: prdata <= {28'h0000000, state, posted_valid, have_bank};
				ebc_pkg::ADDR_BANK: prdata <= {29'h00000000, last_bank_bits};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// counter expiry is the internal ready
	assign cnt_ready = (wait_cnt == 3'h0);
	// external ready is active low: low completes, high extends
	assign ext_ok = !ext_ready_n;

	always_comb
	begin
		case (src)
			ebc_pkg::EBC_SRC_EXT: combined_ready = ext_ok;
			ebc_pkg::EBC_SRC_CNT: combined_ready = cnt_ready;
			// ready pin low finishes at once, otherwise the counter decides
			ebc_pkg::EBC_SRC_AND: combined_ready = ext_ok || cnt_ready;
			// counter gates completion and ready high keeps extending
			ebc_pkg::EBC_SRC_OR: combined_ready = ext_ok && cnt_ready;
			default: combined_ready = cnt_ready;
		endcase
	end

	// a read to a different bank than the last access needs a null cycle
	assign bank_hit = have_bank && !cur.write
		&& (bank_of(cur.addr, bank_mask) != last_bank_bits);

	// single-entry latch: core stalls only while it is occupied or reset is asserted
	assign core_ack = core_req && !posted_valid && presetn;
	assign start = (state == ebc_pkg::EBC_IDLE) && posted_valid;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			posted_valid <= 1'b0;
			posted <= '0;
		end
		else if (core_ack)
		begin
			posted_valid <= 1'b1;
			posted <= core_cmd;
		end
		else if (start)
			posted_valid <= 1'b0;
	end

	assign cur = posted;

	// reset asserted parks the bus in halt at once, with no settle wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ebc_pkg::EBC_HALT;
			wait_cnt <= 3'h0;
			have_bank <= 1'b0;
			last_bank_bits <= 3'h0;
			core_rvalid <= 1'b0;
			core_rdata <= 32'h0000_0000;
			addr_out <= 24'h000000;
			data_out <= 32'h0000_0000;
			rw_out <= 1'b1;
		end
		else
		begin
			core_rvalid <= 1'b0;
			case (state)
				ebc_pkg::EBC_HALT: state <= ebc_pkg::EBC_IDLE;
				ebc_pkg::EBC_IDLE:
				begin
					if (start)
					begin
						wait_cnt <= ctrl[ebc_pkg::CTRL_WAIT_LSB +: ebc_pkg::CTRL_WAIT_W];
						addr_out <= posted.addr;
						data_out <= posted.data;
						rw_out <= !posted.write;
						if (bank_hit)
							state <= ebc_pkg::EBC_NULL;
						else
							state <= ebc_pkg::EBC_ACCESS;
					end
				end
				ebc_pkg::EBC_NULL: state <= ebc_pkg::EBC_ACCESS;
				ebc_pkg::EBC_ACCESS:
				begin
					if (wait_cnt != 3'h0)
						wait_cnt <= wait_cnt - 3'h1;
					// sampled on each rising edge of the bus clock
					if (combined_ready)
					begin
						state <= ebc_pkg::EBC_IDLE;
						have_bank <= 1'b1;
						last_bank_bits <= bank_of(addr_out, bank_mask);
						if (rw_out)
						begin
							core_rvalid <= 1'b1;
							core_rdata <= data_in;
						end
					end
				end
				default: state <= ebc_pkg::EBC_IDLE;
			endcase
		end
	end

	// float is set at once by reset and clears on the first clock after release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			float_done <= 1'b1;
		else
			float_done <= 1'b0;
	end

	// strobe and pages are the same term of state flop and float input, so timing matches
	assign external_access_strobe = !(state == ebc_pkg::EBC_ACCESS) || !output_float_n;
	assign page_select_q0 = external_access_strobe || (addr_out[23:22] != 2'b00);
	assign page_select_q1 = external_access_strobe || (addr_out[23:22] != 2'b01);
	assign page_select_q2 = external_access_strobe || (addr_out[23:22] != 2'b10);
	assign page_select_q3 = external_access_strobe || (addr_out[23:22] != 2'b11);

	// float input removes every driver with no clock involved
	assign addr_oe_n = !output_float_n || float_done;
	assign ctrl_oe_n = !output_float_n || float_done;
	assign data_oe_n = !output_float_n || float_done
		|| !((state == ebc_pkg::EBC_ACCESS) && !rw_out);
	// keeper only stands aside while the pins float
	assign keeper_en = output_float_n;
	assign keeper_value = data_out;

	chk_or_extend: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b11 && ext_ready_n)
		|=> state == ebc_pkg::EBC_ACCESS)
		else $error("or mode ended while ready high");

	chk_and_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b10 && !ext_ready_n)
		|=> state == ebc_pkg::EBC_IDLE)
		else $error("and mode did not finish at once");

	chk_ext_only: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b00)
		|=> (state == ebc_pkg::EBC_IDLE) == !$past(ext_ready_n))
		else $error("external-only source misbehaved");

	chk_cnt_load: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> wait_cnt == ctrl[7:5])
		else $error("wait counter not loaded");

	chk_null_read: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_NULL) |-> ($past(state) == ebc_pkg::EBC_IDLE) && rw_out)
		else $error("null cycle without bank change read");

	chk_page_one: assert property (@(posedge pclk) disable iff (!presetn)
		$countones({page_select_q0, page_select_q1, page_select_q2, page_select_q3})
		== (external_access_strobe ? 4 : 3))
		else $error("page decode wrong");

	chk_post_hold: assert property (@(posedge pclk) disable iff (!presetn)
		core_ack |=> posted_valid && !core_ack)
		else $error("post latch overrun");

	chk_float_off: assert property (@(posedge pclk) disable iff (!presetn)
		!output_float_n |-> addr_oe_n && data_oe_n && ctrl_oe_n && !keeper_en)
		else $error("outputs driven under float");

	chk_strobe_page: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(external_access_strobe) |-> !(page_select_q0 && page_select_q1
		&& page_select_q2 && page_select_q3))
		else $error("page not with strobe");

	chk_page_low: assert property (@(posedge pclk) disable iff (!presetn)
		(!external_access_strobe && addr_out[23:22] == 2'b00) |-> !page_select_q0)
		else $error("lowest page not selected");

	chk_page_idle: assert property (@(posedge pclk) disable iff (!presetn)
		external_access_strobe |-> page_select_q0 && page_select_q1
		&& page_select_q2 && page_select_q3)
		else $error("page active without strobe");

	chk_page_release: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(external_access_strobe) |-> page_select_q0 && page_select_q1
		&& page_select_q2 && page_select_q3)
		else $error("page outlived strobe");

	chk_src_shared: assert property (@(posedge pclk) disable iff (!presetn)
		src == ctrl[4:3])
		else $error("ready source not from control register");

	chk_cnt_done: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b01 && wait_cnt == 3'h0)
		|=> state == ebc_pkg::EBC_IDLE)
		else $error("counter source did not finish");

	chk_cnt_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b01 && wait_cnt != 3'h0)
		|=> state == ebc_pkg::EBC_ACCESS)
		else $error("counter source finished early");

	chk_and_count: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b10 && wait_cnt == 3'h0)
		|=> state == ebc_pkg::EBC_IDLE)
		else $error("and mode ignored counter expiry");

	chk_and_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b10 && ext_ready_n && wait_cnt != 3'h0)
		|=> state == ebc_pkg::EBC_ACCESS)
		else $error("and mode finished before counter");

	chk_or_count: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b11 && wait_cnt != 3'h0)
		|=> state == ebc_pkg::EBC_ACCESS)
		else $error("or mode beat the counter");

	chk_or_finish: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && src == 2'b11 && !ext_ready_n && wait_cnt == 3'h0)
		|=> state == ebc_pkg::EBC_IDLE)
		else $error("or mode did not finish");

	chk_null_once: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_NULL) |=> state == ebc_pkg::EBC_ACCESS)
		else $error("null cycle longer than one");

	chk_write_direct: assert property (@(posedge pclk) disable iff (!presetn)
		(start && posted.write) |=> state == ebc_pkg::EBC_ACCESS)
		else $error("write was pre-extended");

	chk_post_free: assert property (@(posedge pclk) disable iff (!presetn)
		(core_req && !posted_valid) |-> core_ack)
		else $error("empty latch refused a request");

	chk_ready_taken: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && combined_ready) |=> state == ebc_pkg::EBC_IDLE)
		else $error("combined ready not honoured");

	chk_read_return: assert property (@(posedge pclk) disable iff (!presetn)
		core_rvalid |-> rw_out && $past(state) == ebc_pkg::EBC_ACCESS)
		else $error("read data without a read");

	chk_cnt_down: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_ACCESS && wait_cnt != 3'h0)
		|=> wait_cnt == $past(wait_cnt) - 3'h1)
		else $error("wait counter did not step");

	chk_keeper_on: assert property (@(posedge pclk) disable iff (!presetn)
		output_float_n |-> keeper_en)
		else $error("keeper off outside float");

	chk_data_drive: assert property (@(posedge pclk) disable iff (!presetn)
		!data_oe_n |-> state == ebc_pkg::EBC_ACCESS && !rw_out && output_float_n)
		else $error("data driven outside a write");

	chk_halt_leave: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ebc_pkg::EBC_HALT) |=> state == ebc_pkg::EBC_IDLE)
		else $error("bus stuck after reset");
endmodule : ebc_bus_ctrl
`default_nettype wire

// File: test/ebc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model
(
	input wire logic pclk,
	input wire logic strobe_n,
	input wire logic rw,
	input wire logic [23:0] addr,
	input wire logic [31:0] delay,
	output logic ready_n,
	output logic [31:0] rdata
);
	logic [31:0] n = 32'h0;
	always_ff @(posedge pclk)
		n <= strobe_n ? 32'h0 : n + 32'h1;
	// ready stays high to extend until the programmed delay runs out
	assign ready_n = !(!strobe_n && n >= delay);
	// undriven lines toggle so a stale value never passes as read data
	assign rdata = (!strobe_n && rw) ? {8'hA5, addr} : {8'h00, ~addr} ^ {32{pclk}};
endmodule : ebc_mem_model
`default_nettype wire

// File: test/external_bus_wait_page_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module external_bus_wait_page_control_test;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic core_req = 0;
	ebc_pkg::ebc_req_t core_cmd = '0;
	logic output_float_n = 1;
	logic [31:0] dly = 32'h0;
	logic [31:0] prdata, core_rdata, data_out, data_in, kv;
	logic [23:0] addr_out;
	logic pready, pslverr, core_ack, core_rvalid, ready_n, aoe, doe, coe, ken, stb, rw;
	logic q0, q1, q2, q3;
	logic [31:0] seed = 32'h6E6E;
	int n_errors = 0;
	int tests_run = 0;
	always #5 pclk = ~pclk;
	ebc_bus_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_req(core_req), .core_cmd(core_cmd), .core_ack(core_ack),
		.core_rdata(core_rdata), .core_rvalid(core_rvalid), .output_float_n(output_float_n),
		.ext_ready_n(ready_n), .addr_out(addr_out), .addr_oe_n(aoe), .data_out(data_out),
		.data_oe_n(doe), .data_in(data_in), .keeper_value(kv), .keeper_en(ken),
		.external_access_strobe(stb), .rw_out(rw), .ctrl_oe_n(coe), .page_select_q0(q0),
		.page_select_q1(q1), .page_select_q2(q2), .page_select_q3(q3));
	ebc_mem_model u_mem (.pclk(pclk), .strobe_n(stb), .rw(rw), .addr(addr_out),
		.delay(dly), .ready_n(ready_n), .rdata(data_in));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int exp_len(input logic [1:0] s, input int w, input int d);
		case (s)
			ebc_pkg::EBC_SRC_EXT: return d + 1;
			ebc_pkg::EBC_SRC_CNT: return w + 1;
			ebc_pkg::EBC_SRC_AND: return (d < w ? d : w) + 1;
			default: return (d > w ? d : w) + 1;
		endcase
	endfunction : exp_len
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic setc(input logic [2:0] w, input logic [1:0] s, input logic [2:0] b);
		logic [31:0] r;
		logic e;
		apb(1, ebc_pkg::ADDR_CTRL, {24'h0, w, s, b}, r, e);
	endtask : setc
	task automatic xfer(input logic w, input logic [23:0] a, input int d, input int len,
		input int gap);
		int k;
		logic [31:0] v;
		v = rnd();
		@(posedge pclk);
		dly <= d;
		core_req <= 1;
		core_cmd <= '{w, a, v};
		@(negedge pclk);
		while (core_ack !== 1'b1) @(negedge pclk);
		@(posedge pclk);
		core_req <= 0;
		@(negedge pclk);
		for (k = 1; stb !== 1'b0 && k < 50; k++) @(negedge pclk);
		cmp("start", gap, k);
		cmp("page", 4'(~(4'h1 << a[23:22])), {q3, q2, q1, q0});
		cmp("doe", !w, doe);
		cmp("addr", a, addr_out);
		cmp("dir", !w, rw);
		if (w)
			cmp("wdata", v, data_out);
		if (w)
			cmp("keep", v, kv);
		for (k = 0; stb === 1'b0 && k < 50; k++) @(negedge pclk);
		cmp("len", len, k);
		cmp("page_off", 4'hF, {q3, q2, q1, q0});
		for (k = 0; !w && core_rvalid !== 1'b1 && k < 5; k++) @(negedge pclk);
		if (!w)
			cmp("rdata", {8'hA5, a}, core_rdata);
	endtask : xfer
	task automatic complete_run();
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial
	begin
		#100000;
		n_errors++;
		complete_run();
	end
	initial
	begin
		logic [31:0] r;
		logic e;
		repeat (3) @(posedge pclk);
		cmp("rst_pins", 4'hF, {aoe, doe, coe, stb});
		presetn <= 1;
		apb(0, ebc_pkg::ADDR_CTRL, 32'h0, r, e);
		cmp("ctrl", ebc_pkg::CTRL_RESET, r);
		apb(0, 8'h0C, 32'h0, r, e);
		cmp("slverr", 1, e);
		for (int i = 0; i < 12; i++)
		begin
			r = rnd();
			setc(r[2:0], i[1:0], 3'h0);
			xfer(r[3], r[31:8], r[6:4], exp_len(i[1:0], r[2:0], r[6:4]), 2);
		end
		setc(3'h7, ebc_pkg::EBC_SRC_AND, 3'h0);
		xfer(0, 24'h800004, 0, 1, 2);
		setc(3'h0, ebc_pkg::EBC_SRC_CNT, 3'h7);
		xfer(1, 24'h000010, 0, 1, 2);
		xfer(0, 24'h000014, 0, 1, 2);
		xfer(0, 24'hE00010, 0, 1, 3);
		apb(0, ebc_pkg::ADDR_BANK, 32'h0, r, e);
		cmp("bank", 32'h7, r);
		@(posedge pclk);
		output_float_n <= 0;
		#2;
		cmp("float", 4'hE, {aoe, doe, coe, ken});
		@(posedge pclk);
		presetn <= 0;
		#2;
		cmp("float_rst", 5'h1D, {aoe, doe, coe, ken, stb});
		@(posedge pclk);
		output_float_n <= 1;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		#2;
		cmp("keeper", 1, ken);
		xfer(0, 24'h400000, 2, 8, 2);
		complete_run();
	end
endmodule : external_bus_wait_page_control_test
`default_nettype wire
